// ==== core/psc_port.sv ====
/*
 Root-port status/control fields behind an AHB-Lite slave, with sticky
 interrupt status, mask and one level interrupt. Assumes all pins are
 synchronous to hclk and that frame timing supplies EOF2 and SOF pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_port (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Port pins and frame timing
   input wire psc_pkg::psc_line_t line_in,
   input wire logic oc_n,
   input wire logic connected,
   input wire logic low_speed_attached,
   input wire logic eof2_pulse,
   input wire logic eof2_fault,
   input wire logic sof_pulse,
   input wire logic txn_idle,
   input wire logic susp_error,
   // Port drive and status
   output psc_pkg::psc_line_t line_out,
   output logic port_blocked,
   output logic irq
);
   import psc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic susp;
      logic susp_req;
      logic sof_seen;
      logic oci;
      logic oc_prev;
      logic rst;
      logic rsm;
      logic [1:0] line;
      logic pedc;
      logic j_seen;
      psc_eop_t eop;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_mask;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic ready;
      psc_line_t drv;
      logic blocked;
      logic irq;
   } psc_state_t;

   psc_state_t state_q;
   psc_state_t state_d;

   logic rsm_done;
   logic [EOP_CNT_W-1:0] eop_cnt;
   logic eop_done;
   logic rsm_run;
   logic oc_act;
   logic k_now;
   logic j_now;
   logic [15:0] psc_rd;

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   psc_timer #(
      .W(RSM_CNT_W),
      .LIMIT(RSM_CNT_W'(RESUME_CYC))
   ) u_rsm_timer (
      .clk(hclk),
      .rst_n(hresetn),
      .run(rsm_run),
      .cnt(),
      .done(rsm_done)
   );

   psc_timer #(
      .W(EOP_CNT_W),
      .LIMIT(EOP_CNT_W'(EOP_CYC - 1))
   ) u_eop_timer (
      .clk(hclk),
      .rst_n(hresetn),
      .run(state_q.eop != DRV_IDLE),
      .cnt(eop_cnt),
      .done(eop_done)
   );

   // ----------------------------------------------------------------
   // Line decode and readback
   // ----------------------------------------------------------------
   // Overcurrent, speed and connect read live; line status is the EOF2 snapshot
   always_comb begin
      oc_act = ~oc_n;
      // J and K swap polarity for a low-speed device
      j_now = low_speed_attached ? (~line_in.dp & line_in.dm) : (line_in.dp & ~line_in.dm);
      k_now = low_speed_attached ? (line_in.dp & ~line_in.dm) : (~line_in.dp & line_in.dm);
      rsm_run = state_q.en && state_q.susp && state_q.j_seen && k_now && !state_q.rsm; // R9
      psc_rd = 16'h0000;
      psc_rd[B_CCS] = connected;
      psc_rd[B_EN] = state_q.en; // R16
      psc_rd[B_SUSP] = state_q.susp; // R16
      psc_rd[B_PEDC] = state_q.pedc;
      psc_rd[B_LINE_DP] = state_q.line[0]; // R12
      psc_rd[B_LINE_DM] = state_q.line[1]; // R12
      psc_rd[B_RSM] = state_q.rsm; // R11
      psc_rd[B_RSVD1] = PSC_RESET[B_RSVD1]; // R7
      psc_rd[B_LS] = low_speed_attached; // R6
      psc_rd[B_RST] = state_q.rst;
      psc_rd[B_OCA] = oc_act; // R4
      psc_rd[B_OCI] = state_q.oci;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;

      // Bus data phase: read answers after one wait state
      // Read data come from a register, so the slave stalls once per read;
      // writes take no wait and land at the end of their data phase
      if (state_q.rd_pend) begin
         state_d.rd_pend = 1'b0;
         state_d.ready = 1'b1;
         case (state_q.addr)
            PSC_OFS: state_d.rdata = {16'h0000, psc_rd};
            IRQ_ST_OFS: state_d.rdata = {29'h0000000, state_q.irq_st};
            IRQ_MASK_OFS: state_d.rdata = {29'h0000000, state_q.irq_mask};
            CTRL_OFS: state_d.rdata = {31'h00000000, state_q.rst};
            default: state_d.rdata = 32'h00000000;
         endcase
      end

      // Bus write data phase; hardware sets below override the clears
      if (state_q.wr_pend) begin
         state_d.wr_pend = 1'b0;
         case (state_q.addr)
            PSC_OFS: begin
               if (hwdata[B_OCI]) begin
                  state_d.oci = 1'b0; // R3 R17
               end
               if (hwdata[B_PEDC]) begin
                  state_d.pedc = 1'b0; // R15 R17
               end
               // Software disable leaves the change flag alone
               // Enable only takes with a device present and no port reset
               if (!hwdata[B_EN]) begin
                  state_d.en = 1'b0;
                  state_d.susp = 1'b0;
                  state_d.susp_req = 1'b0;
               end else if (!state_q.en && connected && !state_q.rst) begin
                  state_d.en = 1'b1;
               end
               // Suspend is only requested; it takes hold once the bus is quiet, or after one SOF on an error
               if (!hwdata[B_SUSP]) begin
                  state_d.susp = 1'b0;
                  state_d.susp_req = 1'b0;
               end else if (state_q.en && !state_q.susp) begin
                  state_d.susp_req = 1'b1;
               end
               // Zero after one ends the driven resume with an EOP;
               // the bit keeps reading one until that EOP is over
               if (hwdata[B_RSM] && !state_q.rsm) begin
                  state_d.rsm = 1'b1; // R8
               end else if (!hwdata[B_RSM] && state_q.rsm && state_q.eop == DRV_IDLE) begin
                  state_d.eop = DRV_SE0; // R11
               end
            end
            IRQ_ST_OFS: state_d.irq_st = state_q.irq_st & ~hwdata[IRQ_W-1:0];
            IRQ_MASK_OFS: state_d.irq_mask = hwdata[IRQ_W-1:0];
            CTRL_OFS: state_d.rst = hwdata[B_CTRL_RST];
            default: state_d.wr_pend = 1'b0;
         endcase
      end

      // Address phase
      // Not taken in the read wait state; the master holds it until ready
      if (hsel && htrans[1] && hready && state_q.ready) begin
         state_d.addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
         if (hwrite) begin
            state_d.wr_pend = 1'b1;
         end else begin
            state_d.rd_pend = 1'b1;
            state_d.ready = 1'b0;
         end
      end

      // Overcurrent edge
      // Previous level resets inactive, so a pin already active at reset release makes an edge
      state_d.oc_prev = oc_act;
      if (oc_act && !state_q.oc_prev) begin
         state_d.oci = 1'b1; // R2 R17
         state_d.irq_st[IRQ_OC] = 1'b1;
      end

      // Suspend entry; an error lets one SOF through first
      // Without an error, suspend waits for the transaction in flight to end
      if (!state_q.susp_req) begin
         state_d.sof_seen = 1'b0;
      end else if (state_q.en) begin
         if (txn_idle || (susp_error && state_q.sof_seen)) begin
            state_d.susp = 1'b1; // R1
            state_d.susp_req = 1'b0;
            state_d.sof_seen = 1'b0;
         end else if (susp_error && sof_pulse) begin
            state_d.sof_seen = 1'b1; // R1
         end
      end

      // Resume detection
      // A J must follow suspend before a K counts; losing the K restarts the count
      if (!state_q.susp || state_q.rsm) begin
         state_d.j_seen = 1'b0;
      end else if (j_now) begin
         state_d.j_seen = 1'b1;
      end
      if (rsm_done) begin
         state_d.rsm = 1'b1; // R9
         state_d.j_seen = 1'b0;
         state_d.irq_st[IRQ_RSM] = 1'b1;
      end

      // Low-speed EOP: two bits of SE0, one bit of J
      // The timer counts from zero on the first SE0 cycle, so both
      // limits stop one count short to keep two and one bit times
      case (state_q.eop)
         DRV_IDLE: state_d.eop = state_d.eop;
         DRV_SE0: begin
            if (eop_cnt == EOP_CNT_W'(EOP_SE0_CYC - 1)) begin
               state_d.eop = DRV_J;
            end
         end
         DRV_J: begin
            if (eop_done) begin
               state_d.eop = DRV_IDLE;
               state_d.rsm = 1'b0; // R11
               state_d.susp = 1'b0;
            end
         end
         default: state_d.eop = DRV_IDLE;
      endcase

      // Line status sample
      // Sampled only at EOF2 so the field cannot change mid-frame
      if (eof2_pulse) begin
         state_d.line = {line_in.dm, line_in.dp}; // R13
      end

      // Hardware disable
      // Only a disconnect or an EOF2 fault sets the change flag
      if (state_q.en && (!connected || (eof2_pulse && eof2_fault))) begin
         state_d.en = 1'b0;
         state_d.susp = 1'b0;
         state_d.susp_req = 1'b0;
         state_d.pedc = 1'b1; // R14 R17
         state_d.irq_st[IRQ_PEDC] = 1'b1;
      end

      // Port reset holds the port disabled
      // Wins over any enable written in the same cycle
      if (state_q.rst) begin
         state_d.en = 1'b0; // R5
         state_d.susp = 1'b0;
         state_d.susp_req = 1'b0;
      end

      // Line drive
      // Port reset first, then the EOP, then the resume K; taken from
      // the next state so pins and status bits move together
      state_d.drv = '{dp: 1'b0, dm: 1'b0, oe: 1'b0};
      if (state_d.rst || state_d.eop == DRV_SE0) begin
         state_d.drv.oe = 1'b1; // R5 R11
      end else if (state_d.eop == DRV_J) begin
         state_d.drv = '{dp: ~low_speed_attached, dm: low_speed_attached, oe: 1'b1};
      end else if (state_d.rsm && state_d.en) begin
         state_d.drv = '{dp: low_speed_attached, dm: ~low_speed_attached, oe: 1'b1}; // R8 R10
      end

      state_d.blocked = state_d.susp && state_d.en; // R16
      state_d.irq = |(state_d.irq_st & state_d.irq_mask);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= '{
            en: 1'b0,
            susp: 1'b0,
            susp_req: 1'b0,
            sof_seen: 1'b0,
            oci: 1'b0,
            oc_prev: 1'b0,
            rst: 1'b0,
            rsm: 1'b0,
            line: 2'b00,
            pedc: 1'b0,
            j_seen: 1'b0,
            eop: DRV_IDLE,
            irq_st: 3'h0,
            irq_mask: 3'h0,
            wr_pend: 1'b0,
            rd_pend: 1'b0,
            addr: 8'h00,
            rdata: 32'h00000000,
            ready: 1'b1,
            drv: '{dp: 1'b0, dm: 1'b0, oe: 1'b0},
            blocked: 1'b0,
            irq: 1'b0
         };
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = state_q.rdata;
   assign hreadyout = state_q.ready;
   // Every transfer is answered OKAY
   assign hresp = 1'b0;
   assign line_out = state_q.drv;
   assign port_blocked = state_q.blocked;
   assign irq = state_q.irq;

endmodule : psc_port
`default_nettype wire

// ==== core/psc_pkg.sv ====
/*
 Constants, field positions, timing counts and carrier types for the
 root-port status/control block. Assumes a 40 MHz hclk.
*/
// Functional notes
// R1 - Error while suspending allows one SOF
// R2 - Overcurrent going active sets bit 11
// R3 - Bit 11 cleared only by writing one
// R4 - Bit 10 tracks live overcurrent pin
// R5 - Port reset disables port, drives reset
// R6 - Bit 8 reports low-speed device, read-only
// R7 - Bit 7 reads one, ignores writes
// R8 - Writing one to bit 6 drives resume
// R9 - Suspended J-to-K for 32 us sets resume
// R10 - Resume set while suspended echoes K-state
// R11 - Clearing resume sends low-speed EOP first
// R12 - Line status: D+ bit 4, D- bit 5
// R13 - Line status refreshed only at EOF2
// R14 - Enable change set on disconnect or EOF2
// R15 - Enable change cleared by writing one
// R16 - Bits 12,2 encode disabled/enabled/suspended
// R17 - Zero writes keep flags; set beats clear
package psc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] PSC_OFS = 8'h00;
   localparam logic [7:0] IRQ_ST_OFS = 8'h04;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
   localparam logic [7:0] CTRL_OFS = 8'h0C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int B_CCS = 0;
   localparam int B_EN = 2;
   localparam int B_PEDC = 3;
   localparam int B_LINE_DP = 4;
   localparam int B_LINE_DM = 5;
   localparam int B_RSM = 6;
   localparam int B_RSVD1 = 7;
   localparam int B_LS = 8;
   localparam int B_RST = 9;
   localparam int B_OCA = 10;
   localparam int B_OCI = 11;
   localparam int B_SUSP = 12;
   localparam int B_CTRL_RST = 0;
   localparam int IRQ_OC = 0;
   localparam int IRQ_PEDC = 1;
   localparam int IRQ_RSM = 2;
   localparam int IRQ_W = 3;
   localparam logic [15:0] PSC_RESET = 16'h0080;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 25;
   localparam int RESUME_US = 32;
   localparam int RESUME_CYC = (RESUME_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RSM_CNT_W = 11;
   localparam int LS_BIT_NS = 667;
   localparam int LS_BIT_CYC = (LS_BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int EOP_CNT_W = 7;
   localparam int EOP_SE0_CYC = 2 * LS_BIT_CYC;
   localparam int EOP_CYC = 3 * LS_BIT_CYC;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DRV_IDLE = 2'b00,
      DRV_SE0 = 2'b01,
      DRV_J = 2'b10
   } psc_eop_t;

   typedef struct packed {
      logic dp;
      logic dm;
      logic oe;
   } psc_line_t;

endpackage : psc_pkg

// ==== core/psc_timer.sv ====
/*
 Cycle counter that runs while enabled and flags when its limit is hit.
 Assumes run is synchronous to clk; dropping run restarts the count.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_timer #(
   parameter int W = 8,
   parameter logic [W-1:0] LIMIT = '1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   // Status
   output logic [W-1:0] cnt,
   output logic done
);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (!run) begin
         cnt <= '0;
      end else if (cnt != LIMIT) begin
         cnt <= cnt + 1'b1;
      end
   end

   assign done = run && (cnt == LIMIT);

endmodule : psc_timer
`default_nettype wire

// ==== tb/psc_monitor.sv ====
/*
 Port-level checker for the root-port status/control block.
 Assumes it is bound to psc_port and that everything runs on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_monitor (
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   // Port pins
   input wire psc_pkg::psc_line_t line_in,
   input wire logic oc_n,
   input wire logic low_speed_attached,
   input wire logic eof2_pulse,
   input wire psc_pkg::psc_line_t line_out,
   input wire logic port_blocked
);
   import psc_pkg::*;
   // ---------------------------------------------
   // Address phase tracking and line snapshot
   // ---------------------------------------------
   logic take;
   logic rd_psc;
   logic wr_q;
   logic [7:0] adr_q;
   logic [1:0] snap_q;
   assign take = hsel && htrans[1] && hready && hreadyout;
   assign rd_psc = take && !hwrite && haddr == {24'h000000, PSC_OFS};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         adr_q <= 8'h00;
         snap_q <= 2'h0;
      end else begin
         wr_q <= take && hwrite;
         adr_q <= haddr[7:0];
         if (eof2_pulse) begin
            snap_q <= {line_in.dm, line_in.dp};
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_fast_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   rsvd_one_a: assert property (rd_psc |-> ##2 hrdata[B_RSVD1])
      else $error("reserved bit read zero");
   oca_live_a: assert property (rd_psc |-> ##2 hrdata[B_OCA] == !$past(oc_n))
      else $error("overcurrent active wrong");
   ls_live_a: assert property (rd_psc |-> ##2 hrdata[B_LS] == $past(low_speed_attached))
      else $error("low speed bit wrong");
   line_snap_a: assert property (rd_psc |-> ##2 hrdata[5:4] == $past(snap_q))
      else $error("line status not the frame snapshot");
   rst_se0_a: assert property (wr_q && adr_q == CTRL_OFS && hwdata[B_CTRL_RST]
      |-> ##[1:3] line_out == 3'b001)
      else $error("port reset not driving SE0");
   rsm_k_a: assert property (wr_q && adr_q == PSC_OFS && hwdata[B_RSM] && port_blocked
      |-> ##[1:3] line_out == 3'b011)
      else $error("resume not driving K");
endmodule : psc_monitor
bind psc_port psc_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .line_in(line_in), .oc_n(oc_n),
   .low_speed_attached(low_speed_attached), .eof2_pulse(eof2_pulse),
   .line_out(line_out), .port_blocked(port_blocked));
`default_nettype wire

// ==== tb/psc_dev_model.sv ====
/*
 Model of the device on the cable side of the root port.
 Assumes its tasks are called just after a rising hclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_dev_model (
   // Clock and host drive
   input wire logic hclk,
   input wire psc_pkg::psc_line_t line_out,
   // Cable side
   output psc_pkg::psc_line_t line_in,
   output logic connected,
   output logic low_speed_attached
);
   import psc_pkg::*;
   // ---------------------------------------------
   // Line levels; host drive wins, pull-downs give SE0 when detached
   // ---------------------------------------------
   psc_line_t dev_q;
   assign line_in = line_out.oe ? line_out : dev_q;
   initial begin
      dev_q = 3'b000;
      connected = 1'b0;
      low_speed_attached = 1'b0;
   end
   task attach(input logic ls);
      connected <= 1'b1;
      low_speed_attached <= ls;
      dev_q <= ls ? 3'b010 : 3'b100;
   endtask : attach
   task detach();
      connected <= 1'b0;
      low_speed_attached <= 1'b0;
      dev_q <= 3'b000;
   endtask : detach
   // Full-speed J, then K held n cycles, then idle J again
   task resume(input int n);
      dev_q <= 3'b100;
      repeat (4) @(posedge hclk);
      dev_q <= 3'b010;
      repeat (n) @(posedge hclk);
      dev_q <= 3'b100;
   endtask : resume
endmodule : psc_dev_model
`default_nettype wire

// ==== tb/psc_port_bench.sv ====
/*
 Self-checking bench for psc_port over AHB-Lite with a device model.
 Assumes psc_monitor is bound in; reset is held for 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_port_bench;
   import psc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic oc_n, eof2_pulse, eof2_fault, txn_idle, connected, low_speed_attached;
   logic port_blocked, irq, sof_pulse, susp_error;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   psc_line_t line_in, line_out;
   int err_total, total_checks;
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   psc_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in),
      .oc_n(oc_n), .connected(connected), .low_speed_attached(low_speed_attached),
      .eof2_pulse(eof2_pulse), .eof2_fault(eof2_fault), .sof_pulse(sof_pulse),
      .txn_idle(txn_idle), .susp_error(susp_error), .line_out(line_out),
      .port_blocked(port_blocked), .irq(irq));
   psc_dev_model i_dev (.hclk(hclk), .line_out(line_out), .line_in(line_in),
      .connected(connected), .low_speed_attached(low_speed_attached));
   // ---------------------------------------------
   // Bus tasks and compares
   // ---------------------------------------------
   task results();
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
      q = hrdata;
      if (n >= 99) begin
         err_total++;
         results();
      end
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   // Polls up to tries reads for the masked value
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int tries);
      for (int k = 0; k < tries; k++) begin
         bus(1'b0, a, 32'h00000000);
         if ((q & m) === e) break;
      end
      total_checks++;
      if ((q & m) !== e) begin
         err_total++;
         $display("unexpected at %0t: reg %h read %h", $time, a, q);
      end
   endtask : rd
   task pin(input logic [2:0] got, input logic [2:0] e);
      total_checks++;
      if (got !== e) begin
         err_total++;
         $display("unexpected at %0t: pins %b", $time, got);
      end
   endtask : pin
   task eof2(input logic f);
      eof2_fault <= f;
      eof2_pulse <= 1'b1;
      @(posedge hclk);
      eof2_fault <= 1'b0;
      eof2_pulse <= 1'b0;
      @(posedge hclk);
   endtask : eof2
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {oc_n, eof2_pulse, eof2_fault, txn_idle, sof_pulse, susp_error} = 6'b100100;
      err_total = 0;
      total_checks = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rd(PSC_OFS, 32'hFFFF, 32'h0080, 1);
      wr(PSC_OFS, 32'h0BB8);
      rd(PSC_OFS, 32'hFFFF, 32'h0080, 1);
      wr(IRQ_MASK_OFS, 32'h7);
      i_dev.attach(1'b1);
      rd(PSC_OFS, 32'h0130, 32'h0100, 1);
      eof2(1'b0);
      rd(PSC_OFS, 32'h0030, 32'h0020, 1);
      wr(PSC_OFS, 32'h0004);
      i_dev.detach();
      rd(PSC_OFS, 32'h000C, 32'h0008, 5);
      wr(PSC_OFS, 32'h0008);
      rd(PSC_OFS, 32'h0008, 32'h0000, 1);
      pin({2'b00, irq}, 3'b001);
      wr(IRQ_ST_OFS, 32'h7);
      repeat (2) @(posedge hclk);
      pin({2'b00, irq}, 3'b000);
      oc_n <= 1'b0;
      rd(PSC_OFS, 32'h0C00, 32'h0C00, 3);
      oc_n <= 1'b1;
      rd(PSC_OFS, 32'h0C00, 32'h0800, 3);
      wr(PSC_OFS, 32'h0000);
      rd(PSC_OFS, 32'h0800, 32'h0800, 1);
      wr(PSC_OFS, 32'h0800);
      rd(PSC_OFS, 32'h0800, 32'h0000, 1);
      i_dev.attach(1'b0);
      wr(PSC_OFS, 32'h0004);
      eof2(1'b1);
      rd(PSC_OFS, 32'h003C, 32'h0018, 1);
      wr(PSC_OFS, 32'h000C);
      wr(PSC_OFS, 32'h0000);
      rd(PSC_OFS, 32'h000C, 32'h0000, 1);
      wr(PSC_OFS, 32'h0004);
      wr(CTRL_OFS, 32'h1);
      rd(PSC_OFS, 32'h0204, 32'h0200, 1);
      pin(line_out, 3'b001);
      wr(CTRL_OFS, 32'h0);
      wr(PSC_OFS, 32'h0004);
      wr(PSC_OFS, 32'h1004);
      rd(PSC_OFS, 32'h1004, 32'h1004, 5);
      wr(PSC_OFS, 32'h1044);
      repeat (3) @(posedge hclk);
      pin(line_out, 3'b011);
      wr(PSC_OFS, 32'h1004);
      rd(PSC_OFS, 32'h0040, 32'h0040, 1);
      rd(PSC_OFS, 32'h0040, 32'h0000, 60);
      txn_idle <= 1'b0;
      susp_error <= 1'b1;
      wr(PSC_OFS, 32'h1004);
      rd(PSC_OFS, 32'h1000, 32'h0000, 1);
      sof_pulse <= 1'b1;
      @(posedge hclk);
      sof_pulse <= 1'b0;
      rd(PSC_OFS, 32'h1004, 32'h1004, 5);
      pin({1'b0, port_blocked, hresp}, 3'b010);
      txn_idle <= 1'b1;
      susp_error <= 1'b0;
      i_dev.resume(1200);
      rd(PSC_OFS, 32'h0040, 32'h0000, 1);
      i_dev.resume(1300);
      rd(PSC_OFS, 32'h0040, 32'h0040, 5);
      pin(line_out, 3'b011);
      results();
   end
endmodule : psc_port_bench
`default_nettype wire
